/* File: pkg/sft_consts.svh */
// Register offsets, field positions, reset values and timing constants of the serial transceiver
// Contract
// - Enabled transmitter drives the serial output pin instead of the port.
// - Synchronous mode clocks the transmitter from the external bit clock.
// - Writing the data register loads the transmit buffer and starts sending.
// - Shifter takes the buffer when idle or right after the last stop bit.
// - Unused upper data bits are ignored for characters under eight bits.
// - Nine-bit characters take bit nine from a control bit set beforehand.
// - Buffer-empty flag is one when empty, zero while a character waits.
// - Writing the data register clears the buffer-empty flag.
// - Buffer-empty interrupt is requested as long as flag and enable are set.
// - Done flag sets when the frame is out and the buffer is empty.
// - Done flag clears on interrupt service or on writing one to it.
// - Done interrupt is requested when the done flag sets and is enabled.
// - With parity on, parity goes between last data bit and first stop.
// - Transmit disable waits for shifter and buffer to drain, then releases pin.
// - Enabled receiver takes the serial input pin as its input.
// - Synchronous mode samples received bits on the external bit clock.
// - Receiver starts on a valid start bit and shifts bits until stop.
// - Receiver ignores any second stop bit.
// - First stop bit moves the frame into the receive buffer.
// - Unused upper bits of received data read as zero.
// - Frame is start, five to nine data bits LSB first, parity, stops.
// - Parity is XOR of data bits, inverted for odd parity.
// - Bit is sixteen divider ticks, eight with double speed.
// - Polarity zero: data changes on rising, sampled on falling clock edge.
`ifndef SFT_CONSTS_SVH
`define SFT_CONSTS_SVH

`define SFT_ADR_DATA 3'h0
`define SFT_ADR_STAT 3'h1
`define SFT_ADR_CTRL 3'h2
`define SFT_ADR_FMT 3'h3
`define SFT_ADR_BAUDL 3'h4
`define SFT_ADR_BAUDH 3'h5

`define SFT_ST_RXRDY 7
`define SFT_ST_DONE 6
`define SFT_ST_EMPTY 5
`define SFT_ST_DBL 1

`define SFT_CT_DONE_IE 6
`define SFT_CT_EMPTY_IE 5
`define SFT_CT_RXON 4
`define SFT_CT_TXON 3
`define SFT_CT_RX9 1
`define SFT_CT_TX9 0

`define SFT_FM_PAR 3
`define SFT_FM_ODD 4
`define SFT_FM_TWO 5
`define SFT_FM_SYNC 6
`define SFT_FM_POL 7

`define SFT_FMT_RST 8'h03
`define SFT_OVS_NORM 4'hf
`define SFT_OVS_DBL 4'h7
`define SFT_MID_NORM 4'h7
`define SFT_MID_DBL 4'h3

`endif

/* File: pkg/sft_pkg.sv */
// Types shared by the serial transceiver
package sft_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sft_bus_t;
    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} sft_tx_st_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} sft_rx_st_t;
endpackage : sft_pkg

/* File: verilog/sft_top.sv */
// Serial frame transceiver: register port, transmit and receive paths
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sft_consts.svh"
module sft_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire sft_pkg::sft_bus_t bus,
    output logic [7:0] rdata,
    input wire logic global_irq_en,
    input wire logic tx_done_irq_ack,
    output logic tx_empty_irq,
    output logic tx_done_irq,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    input wire logic serial_in_pin,
    input wire logic bit_clock_pin,
    output logic rx_pin_claimed
);
    import sft_pkg::*;

    function automatic logic [3:0] char_bits(input logic [2:0] code);
        case (code)
            3'h0: char_bits = 4'h5;
            3'h1: char_bits = 4'h6;
            3'h2: char_bits = 4'h7;
            3'h7: char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction : char_bits

    function automatic logic [8:0] mask_chr(input logic [8:0] d, input logic [3:0] n);
        mask_chr = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                mask_chr[i] = d[i];
            end
        end
    endfunction : mask_chr

    // Software-visible state
    logic [7:0] fmt;
    logic [11:0] baud_divider;
    logic double_speed, transmitter_on, receiver_on, tx_ninth_bit;
    logic tx_empty_irq_en, tx_done_irq_en, tx_done_flag, rx_data_ready;
    logic [7:0] tx_buf;
    logic tx_buf9, buf_full;
    logic [8:0] rx_buf;

    logic [2:0] char_size_code;
    logic parity_on, parity_odd, two_stop_sel, sync_mode, clock_polarity_sel;
    assign char_size_code = fmt[2:0];
    assign parity_on = fmt[`SFT_FM_PAR];
    assign parity_odd = fmt[`SFT_FM_ODD];
    assign two_stop_sel = fmt[`SFT_FM_TWO];
    assign sync_mode = fmt[`SFT_FM_SYNC];
    assign clock_polarity_sel = fmt[`SFT_FM_POL];

    logic [3:0] nbits;
    assign nbits = char_bits(char_size_code);

    logic wr_data, wr_stat, wr_ctrl, rd_data;
    assign wr_data = bus.wr && bus.addr == `SFT_ADR_DATA;
    assign wr_stat = bus.wr && bus.addr == `SFT_ADR_STAT;
    assign wr_ctrl = bus.wr && bus.addr == `SFT_ADR_CTRL;
    assign rd_data = bus.rd && bus.addr == `SFT_ADR_DATA;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fmt <= `SFT_FMT_RST;
            baud_divider <= 12'h000;
            double_speed <= 1'b0;
            transmitter_on <= 1'b0;
            receiver_on <= 1'b0;
            tx_ninth_bit <= 1'b0;
            tx_empty_irq_en <= 1'b0;
            tx_done_irq_en <= 1'b0;
        end else if (bus.wr) begin
            case (bus.addr)
                `SFT_ADR_STAT: double_speed <= bus.wdata[`SFT_ST_DBL];
                `SFT_ADR_CTRL: begin
                    tx_done_irq_en <= bus.wdata[`SFT_CT_DONE_IE];
                    tx_empty_irq_en <= bus.wdata[`SFT_CT_EMPTY_IE];
                    receiver_on <= bus.wdata[`SFT_CT_RXON];
                    transmitter_on <= bus.wdata[`SFT_CT_TXON];
                    tx_ninth_bit <= bus.wdata[`SFT_CT_TX9];
                end
                `SFT_ADR_FMT: fmt <= bus.wdata;
                `SFT_ADR_BAUDL: baud_divider[7:0] <= bus.wdata;
                `SFT_ADR_BAUDH: baud_divider[11:8] <= bus.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                `SFT_ADR_DATA: rdata <= rx_buf[7:0];
                `SFT_ADR_STAT: rdata <= {rx_data_ready, tx_done_flag, !buf_full, 3'h0, double_speed, 1'b0};
                `SFT_ADR_CTRL: rdata <= {1'b0, tx_done_irq_en, tx_empty_irq_en, receiver_on,
                                         transmitter_on, 1'b0, rx_buf[8], tx_ninth_bit};
                `SFT_ADR_FMT: rdata <= fmt;
                `SFT_ADR_BAUDL: rdata <= baud_divider[7:0];
                `SFT_ADR_BAUDH: rdata <= {4'h0, baud_divider[11:8]};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Pin synchronisers; only the second and third stages feed logic
    logic rx_s1, rx_s2, rx_s3, ck_s1, ck_s2, ck_s3;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
        end else begin
            rx_s1 <= serial_in_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            ck_s1 <= bit_clock_pin;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
        end
    end

    // External clock must stay below a quarter of ref_clk for the edge detector to see it
    logic ck_rise, ck_fall, chg_edge, smp_edge;
    assign ck_rise = ck_s2 && !ck_s3;
    assign ck_fall = !ck_s2 && ck_s3;
    assign chg_edge = clock_polarity_sel ? ck_fall : ck_rise;
    assign smp_edge = clock_polarity_sel ? ck_rise : ck_fall;

    // Baud divider: one tick every baud_divider+1 clocks
    logic [11:0] bcnt;
    logic tick;
    assign tick = bcnt == 12'h000;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bcnt <= 12'h000;
        end else begin
            bcnt <= tick ? baud_divider : bcnt - 12'h001;
        end
    end

    logic [3:0] ovs_lim, mid_lim;
    assign ovs_lim = double_speed ? `SFT_OVS_DBL : `SFT_OVS_NORM;
    assign mid_lim = double_speed ? `SFT_MID_DBL : `SFT_MID_NORM;

    // Transmit bit pacing
    logic [3:0] txp;
    logic tx_step;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            txp <= 4'h0;
        end else if (tick) begin
            txp <= (txp >= ovs_lim) ? 4'h0 : txp + 4'h1;
        end
    end
    assign tx_step = sync_mode ? chg_edge : (tick && txp >= ovs_lim);

    // Transmitter
    sft_tx_st_t tx_st;
    logic [8:0] tx_sh;
    logic tx_par, tx_stop2;
    logic [3:0] tcnt;
    logic tx_run;
    logic tx_load, tx_last_stop;
    assign tx_last_stop = tx_st == T_STOP && tx_step && (tx_stop2 || !two_stop_sel);
    assign tx_load = buf_full && tx_run && ((tx_st == T_IDLE && tx_step) || tx_last_stop);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st <= T_IDLE;
            tx_sh <= 9'h000;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            tcnt <= 4'h0;
            serial_out_pin_o <= 1'b1;
        end else if (tx_load) begin
            tx_sh <= mask_chr({tx_buf9, tx_buf}, nbits);
            tx_par <= ^mask_chr({tx_buf9, tx_buf}, nbits) ^ parity_odd;
            tcnt <= 4'h0;
            tx_st <= T_START;
            serial_out_pin_o <= 1'b0;
        end else if (tx_step) begin
            case (tx_st)
                T_START: begin
                    tx_st <= T_DATA;
                    serial_out_pin_o <= tx_sh[0];
                    tx_sh <= {1'b0, tx_sh[8:1]};
                    tcnt <= 4'h1;
                end
                T_DATA: begin
                    if (tcnt == nbits) begin
                        tx_st <= parity_on ? T_PAR : T_STOP;
                        serial_out_pin_o <= parity_on ? tx_par : 1'b1;
                        tx_stop2 <= 1'b0;
                    end else begin
                        serial_out_pin_o <= tx_sh[0];
                        tx_sh <= {1'b0, tx_sh[8:1]};
                        tcnt <= tcnt + 4'h1;
                    end
                end
                T_PAR: begin
                    tx_st <= T_STOP;
                    serial_out_pin_o <= 1'b1;
                    tx_stop2 <= 1'b0;
                end
                T_STOP: begin
                    if (tx_last_stop) begin
                        tx_st <= T_IDLE;
                    end
                    tx_stop2 <= 1'b1;
                    serial_out_pin_o <= 1'b1;
                end
                default: begin
                    tx_st <= T_IDLE;
                    serial_out_pin_o <= 1'b1;
                end
            endcase
        end
    end

    // Disable only lands once nothing is left to send
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_run <= 1'b0;
        end else begin
            tx_run <= transmitter_on || (tx_run && (tx_st != T_IDLE || buf_full));
        end
    end
    assign serial_out_pin_oe = tx_run;

    // Transmit buffer; a write while full overwrites the waiting character
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_buf <= 8'h00;
            tx_buf9 <= 1'b0;
            buf_full <= 1'b0;
        end else if (wr_data) begin
            tx_buf <= bus.wdata;
            tx_buf9 <= tx_ninth_bit;
            buf_full <= 1'b1;
        end else if (tx_load) begin
            buf_full <= 1'b0;
        end
    end

    // Set wins over both clears
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_done_flag <= 1'b0;
        end else if (tx_last_stop && !buf_full) begin
            tx_done_flag <= 1'b1;
        end else if (tx_done_irq_ack || (wr_stat && bus.wdata[`SFT_ST_DONE])) begin
            tx_done_flag <= 1'b0;
        end
    end

    assign tx_empty_irq = global_irq_en && tx_empty_irq_en && !buf_full;
    assign tx_done_irq = global_irq_en && tx_done_irq_en && tx_done_flag;

    // Receiver
    sft_rx_st_t rx_st;
    logic [3:0] rxc, rcnt;
    logic [8:0] rx_sh;
    logic rx_sample;
    assign rx_pin_claimed = receiver_on;
    assign rx_sample = sync_mode ? smp_edge
                     : (tick && rxc == (rx_st == R_START ? mid_lim : ovs_lim));

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxc <= 4'h0;
        end else if (rx_st == R_IDLE || rx_sample) begin
            rxc <= 4'h0;
        end else if (tick) begin
            rxc <= rxc + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st <= R_IDLE;
            rx_sh <= 9'h000;
            rcnt <= 4'h0;
        end else if (!receiver_on) begin
            rx_st <= R_IDLE;
        end else begin
            case (rx_st)
                R_IDLE: begin
                    rcnt <= 4'h0;
                    if (!sync_mode && rx_s3 && !rx_s2) begin
                        rx_st <= R_START;
                    end else if (sync_mode && smp_edge && !rx_s2) begin
                        rx_st <= R_DATA;
                    end
                end
                R_START: if (rx_sample) begin
                    rx_st <= rx_s2 ? R_IDLE : R_DATA;
                end
                R_DATA: if (rx_sample) begin
                    rx_sh <= {rx_s2, rx_sh[8:1]};
                    rcnt <= rcnt + 4'h1;
                    if (rcnt + 4'h1 == nbits) begin
                        rx_st <= parity_on ? R_PAR : R_STOP;
                    end
                end
                R_PAR: if (rx_sample) begin
                    rx_st <= R_STOP;
                end
                R_STOP: if (rx_sample) begin
                    rx_st <= R_IDLE;
                end
                default: rx_st <= R_IDLE;
            endcase
        end
    end

    logic rx_done;
    assign rx_done = receiver_on && rx_st == R_STOP && rx_sample;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_buf <= 9'h000;
        end else if (rx_done) begin
            rx_buf <= rx_sh >> (4'h9 - nbits);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_ready <= 1'b0;
        end else if (!receiver_on) begin
            rx_data_ready <= 1'b0;
        end else if (rx_done) begin
            rx_data_ready <= 1'b1;
        end else if (rd_data) begin
            rx_data_ready <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_idle_load;
        tx_st == T_IDLE && buf_full && tx_run && tx_step && !wr_data;
    endsequence
    sequence s_frame_end_empty;
        tx_last_stop && !buf_full && !wr_data;
    endsequence

    AST_LOAD_FROM_IDLE: assert property (s_idle_load |=> tx_st == T_START && !buf_full)
        else $error("buffer not moved into idle shifter");
    AST_WRITE_FILLS: assert property (wr_data |=> buf_full && !tx_empty_irq)
        else $error("data write left buffer empty");
    AST_DONE_SETS: assert property (s_frame_end_empty |=> tx_done_flag && tx_st == T_IDLE)
        else $error("done flag missing after frame");
    AST_DONE_IRQ: assert property ($rose(tx_done_flag) && tx_done_irq_en && global_irq_en |-> tx_done_irq)
        else $error("done interrupt not raised");
    AST_EMPTY_IRQ: assert property (tx_empty_irq |-> !buf_full && tx_empty_irq_en)
        else $error("empty interrupt without cause");
    AST_START_LOW: assert property ($rose(tx_st == T_START) |-> !serial_out_pin_o)
        else $error("start bit not low");
    AST_IDLE_HIGH: assert property (tx_st == T_IDLE && tx_run |-> serial_out_pin_o)
        else $error("idle line not high");
    AST_HOLD_PIN: assert property (tx_run && !transmitter_on && (buf_full || tx_st != T_IDLE)
        |=> serial_out_pin_oe)
        else $error("pin released with data pending");
    AST_RX_STORE: assert property (rx_done |=> rx_data_ready && rx_st == R_IDLE)
        else $error("frame not stored");
    AST_RX_FLUSH: assert property (!receiver_on |=> !rx_data_ready && rx_st == R_IDLE)
        else $error("disabled receiver kept data");
endmodule : sft_top
`default_nettype wire

/* File: test/sft_partner.sv */
// Remote serial partner: captures frames from the transmit line, sends frames on the receive line
`timescale 1ns/1ps
`default_nettype none
module sft_partner (
    input wire logic ref_clk,
    input wire logic line_in,
    input wire logic [3:0] bits,
    input wire logic par_en,
    input wire logic [4:0] bit_clks,
    output logic line_out,
    output logic [8:0] got_word,
    output logic got_par,
    output int got_cnt
);
    initial begin
        line_out = 1'b1;
        got_word = 9'h000;
        got_par = 1'b0;
        got_cnt = 0;
    end
    // Mid-bit sampling tolerates the few clocks of edge skew
    always begin
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge ref_clk);
        got_word = 9'h000;
        for (int i = 0; i < bits; i++) begin
            repeat (bit_clks) @(posedge ref_clk);
            got_word[i] = line_in;
        end
        if (par_en) begin
            repeat (bit_clks) @(posedge ref_clk);
            got_par = line_in;
        end
        repeat (bit_clks) @(posedge ref_clk);
        got_cnt++;
    end
    // A gap of zero starts the next frame right after the last stop bit
    task automatic send(input logic [8:0] data, input logic odd, input logic two_stop, input int gap);
        logic p;
        p = odd;
        repeat (gap) @(posedge ref_clk);
        line_out <= 1'b0;
        repeat (bit_clks) @(posedge ref_clk);
        for (int i = 0; i < bits; i++) begin
            line_out <= data[i];
            p = p ^ data[i];
            repeat (bit_clks) @(posedge ref_clk);
        end
        if (par_en) begin
            line_out <= p;
            repeat (bit_clks) @(posedge ref_clk);
        end
        line_out <= 1'b1;
        repeat (bit_clks * (1 + two_stop)) @(posedge ref_clk);
    endtask : send
    // Low pulse far shorter than half a bit
    task automatic glitch();
        @(posedge ref_clk);
        line_out <= 1'b0;
        repeat (3) @(posedge ref_clk);
        line_out <= 1'b1;
        repeat (bit_clks * 2) @(posedge ref_clk);
    endtask : glitch
endmodule : sft_partner
`default_nettype wire

/* File: test/sft_top_bench.sv */
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "sft_consts.svh"
module sft_top_bench;
    import sft_pkg::*;
    logic ref_clk, arst_n, global_irq_en, tx_done_irq_ack, tx_empty_irq, tx_done_irq;
    logic out_o, out_oe, rx_line, rx_claimed, tx_line, p_par, got_par, p_line, loop, bclk_en, bit_clk;
    sft_bus_t bus;
    logic [7:0] rdata, v;
    logic [3:0] p_bits, bdiv;
    logic [4:0] p_clks;
    logic [8:0] got_word;
    int got_cnt, frames_exp, mismatches, checks_done;
    // A released output pin floats to its pull-up
    assign tx_line = out_oe ? out_o : 1'b1;
    // Synchronous test loops the transmit line back into the receiver
    assign rx_line = loop ? tx_line : p_line;
    assign bit_clk = bdiv[3];
    sft_top u_sft_top (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
        .global_irq_en(global_irq_en), .tx_done_irq_ack(tx_done_irq_ack), .tx_empty_irq(tx_empty_irq),
        .tx_done_irq(tx_done_irq), .serial_out_pin_o(out_o), .serial_out_pin_oe(out_oe),
        .serial_in_pin(rx_line), .bit_clock_pin(bit_clk), .rx_pin_claimed(rx_claimed));
    sft_partner u_sft_partner (.ref_clk(ref_clk), .line_in(tx_line), .bits(p_bits), .par_en(p_par),
        .bit_clks(p_clks), .line_out(p_line), .got_word(got_word), .got_par(got_par), .got_cnt(got_cnt));
    always #50 ref_clk = ~ref_clk;
    // Bit clock of sixteen ref_clk periods; stands still outside the synchronous test
    always @(posedge ref_clk) begin
        if (bclk_en) begin
            bdiv <= bdiv + 4'h1;
        end
    end
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        // One more edge so that state derived from the written register has settled
        @(posedge ref_clk);
        #10;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #10;
        v = rdata;
    endtask : reg_rd
    task automatic wait_frame(input logic [8:0] exp);
        frames_exp++;
        for (int i = 0; i < 600 && got_cnt < frames_exp; i++) @(posedge ref_clk);
        chk("frame count", frames_exp[8:0], got_cnt[8:0]);
        chk("frame data", exp, got_word);
    endtask : wait_frame
    task automatic t_reset();
        reg_rd(`SFT_ADR_STAT);
        chk("status", 9'h020, {1'b0, v});
        reg_rd(`SFT_ADR_FMT);
        chk("format", 9'h003, {1'b0, v});
        reg_rd(3'h7);
        chk("unmapped", 9'h000, {1'b0, v});
        chk("oe", 9'h000, {8'h00, out_oe});
        chk("rx claim", 9'h000, {8'h00, rx_claimed});
    endtask : t_reset
    task automatic t_tx_basic();
        reg_wr(`SFT_ADR_CTRL, 8'h48);
        chk("oe", 9'h001, {8'h00, out_oe});
        chk("idle line", 9'h001, {8'h00, tx_line});
        reg_wr(`SFT_ADR_DATA, 8'ha5);
        wait_frame(9'h0a5);
        repeat (20) @(posedge ref_clk);
        reg_rd(`SFT_ADR_STAT);
        chk("status", 9'h060, {1'b0, v});
        chk("done irq", 9'h001, {8'h00, tx_done_irq});
        reg_wr(`SFT_ADR_STAT, 8'h40);
        reg_rd(`SFT_ADR_STAT);
        chk("status", 9'h020, {1'b0, v});
        chk("done irq", 9'h000, {8'h00, tx_done_irq});
    endtask : t_tx_basic
    task automatic t_back2back();
        reg_wr(`SFT_ADR_CTRL, 8'h28);
        chk("empty irq", 9'h001, {8'h00, tx_empty_irq});
        reg_wr(`SFT_ADR_DATA, 8'h3c);
        repeat (40) @(posedge ref_clk);
        reg_wr(`SFT_ADR_DATA, 8'hc3);
        reg_rd(`SFT_ADR_STAT);
        chk("empty flag", 9'h000, {8'h00, v[`SFT_ST_EMPTY]});
        chk("empty irq", 9'h000, {8'h00, tx_empty_irq});
        wait_frame(9'h03c);
        wait_frame(9'h0c3);
        repeat (20) @(posedge ref_clk);
        chk("empty irq", 9'h001, {8'h00, tx_empty_irq});
        global_irq_en <= 1'b0;
        @(posedge ref_clk);
        #10;
        chk("empty irq", 9'h000, {8'h00, tx_empty_irq});
        @(posedge ref_clk);
        global_irq_en <= 1'b1;
        reg_wr(`SFT_ADR_CTRL, 8'h08);
        chk("empty irq", 9'h000, {8'h00, tx_empty_irq});
    endtask : t_back2back
    task automatic t_parity();
        logic [7:0] d;
        p_bits <= 4'h5;
        p_par <= 1'b1;
        for (int odd = 0; odd < 2; odd++) begin
            reg_wr(`SFT_ADR_FMT, 8'h08 | 8'(odd << 4));
            for (int k = 0; k < 2; k++) begin
                d = k ? 8'he6 : 8'hff;
                reg_wr(`SFT_ADR_DATA, d);
                wait_frame({4'h0, d[4:0]});
                chk("parity", {8'h00, (^d[4:0]) ^ odd[0]}, {8'h00, got_par});
            end
        end
    endtask : t_parity
    task automatic t_9bit();
        // Let the last parity frame finish and set its done flag before clearing it
        repeat (20) @(posedge ref_clk);
        p_bits <= 4'h9;
        p_par <= 1'b0;
        reg_wr(`SFT_ADR_STAT, 8'h40);
        reg_wr(`SFT_ADR_FMT, 8'h07);
        reg_wr(`SFT_ADR_CTRL, 8'h49);
        reg_wr(`SFT_ADR_DATA, 8'h5a);
        chk("done irq", 9'h000, {8'h00, tx_done_irq});
        wait_frame(9'h15a);
        repeat (20) @(posedge ref_clk);
        chk("done irq", 9'h001, {8'h00, tx_done_irq});
        tx_done_irq_ack <= 1'b1;
        @(posedge ref_clk);
        tx_done_irq_ack <= 1'b0;
        @(posedge ref_clk);
        #10;
        chk("done irq", 9'h000, {8'h00, tx_done_irq});
    endtask : t_9bit
    task automatic t_disable();
        p_bits <= 4'h8;
        reg_wr(`SFT_ADR_FMT, 8'h03);
        reg_wr(`SFT_ADR_CTRL, 8'h08);
        reg_wr(`SFT_ADR_DATA, 8'h96);
        repeat (30) @(posedge ref_clk);
        reg_wr(`SFT_ADR_CTRL, 8'h00);
        chk("oe", 9'h001, {8'h00, out_oe});
        wait_frame(9'h096);
        chk("oe", 9'h001, {8'h00, out_oe});
        repeat (20) @(posedge ref_clk);
        chk("oe", 9'h000, {8'h00, out_oe});
    endtask : t_disable
    task automatic t_rx();
        reg_wr(`SFT_ADR_CTRL, 8'h10);
        chk("rx claim", 9'h001, {8'h00, rx_claimed});
        u_sft_partner.send(9'h03c, 1'b0, 1'b0, 3);
        repeat (20) @(posedge ref_clk);
        reg_rd(`SFT_ADR_STAT);
        chk("rx ready", 9'h001, {8'h00, v[`SFT_ST_RXRDY]});
        reg_rd(`SFT_ADR_DATA);
        chk("rx data", 9'h03c, {1'b0, v});
        reg_rd(`SFT_ADR_STAT);
        chk("rx ready", 9'h000, {8'h00, v[`SFT_ST_RXRDY]});
        p_bits <= 4'h6;
        reg_wr(`SFT_ADR_FMT, 8'h21);
        // One stop per frame although two are configured
        u_sft_partner.send(9'h0ea, 1'b0, 1'b0, 1);
        u_sft_partner.send(9'h015, 1'b0, 1'b0, 0);
        repeat (20) @(posedge ref_clk);
        reg_rd(`SFT_ADR_DATA);
        chk("rx data", 9'h015, {1'b0, v});
        u_sft_partner.glitch();
        repeat (200) @(posedge ref_clk);
        reg_rd(`SFT_ADR_STAT);
        chk("rx ready", 9'h000, {8'h00, v[`SFT_ST_RXRDY]});
    endtask : t_rx
    task automatic t_dbl();
        p_bits <= 4'h8;
        p_clks <= 5'h08;
        reg_wr(`SFT_ADR_STAT, 8'h02);
        reg_wr(`SFT_ADR_FMT, 8'h03);
        reg_wr(`SFT_ADR_CTRL, 8'h18);
        u_sft_partner.send(9'h081, 1'b0, 1'b0, 2);
        repeat (20) @(posedge ref_clk);
        reg_rd(`SFT_ADR_DATA);
        chk("rx data", 9'h081, {1'b0, v});
        reg_wr(`SFT_ADR_DATA, 8'h7e);
        wait_frame(9'h07e);
    endtask : t_dbl
    task automatic t_sync();
        loop <= 1'b1;
        bclk_en <= 1'b1;
        p_clks <= 5'h10;
        reg_wr(`SFT_ADR_FMT, 8'h43);
        reg_wr(`SFT_ADR_DATA, 8'h9c);
        wait_frame(9'h09c);
        repeat (40) @(posedge ref_clk);
        reg_rd(`SFT_ADR_DATA);
        chk("sync rx data", 9'h09c, {1'b0, v});
        @(posedge ref_clk);
        bclk_en <= 1'b0;
        loop <= 1'b0;
    endtask : t_sync
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run is under 3000 cycles; allow well over twice that
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        bus = '0;
        global_irq_en = 1'b1;
        tx_done_irq_ack = 1'b0;
        loop = 1'b0;
        bclk_en = 1'b0;
        bdiv = 4'h0;
        p_bits = 4'h8;
        p_par = 1'b0;
        p_clks = 5'h10;
        frames_exp = 0;
        mismatches = 0;
        checks_done = 0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_tx_basic();
        t_back2back();
        t_parity();
        t_9bit();
        t_disable();
        t_rx();
        t_dbl();
        t_sync();
        tally_and_finish();
    end
endmodule : sft_top_bench
`default_nettype wire
